// ---- src/adcsq_map.vh ----
`ifndef ADCSQ_MAP_VH
`define ADCSQ_MAP_VH

// core clock rate and conversion of times into whole cycles
`define ADCSQ_CLK_MHZ 200
`define ADCSQ_CYC_MIN(ns) ((((ns) * `ADCSQ_CLK_MHZ) + 999) / 1000)

// control word and readout layout
`define ADCSQ_CW_BITS 8
`define ADCSQ_CW_VALID_BIT 7
`define ADCSQ_CFG_BITS 7
`define ADCSQ_RESULT_BITS 16
`define ADCSQ_RD_BITS 24
`define ADCSQ_SEQ_DEPTH 16
`define ADCSQ_RESET_CFG 7'h00
`define ADCSQ_RESET_DEPTH 5'h01

// timing as specified for this core, in ns except the wake time in ms
`define ADCSQ_T_CONV_NS 625
`define ADCSQ_T_ACQ_NS 375
`define ADCSQ_MUX_RESET_DELAY_AFTER_CONVERT_NS 20
`define ADCSQ_MUX_RESET_DURATION_CONVERT_NS 60
`define ADCSQ_MUX_RESET_DELAY_AFTER_WORD_NS 20
`define ADCSQ_MUX_RESET_DURATION_WORD_NS 60
`define ADCSQ_T_WAKE_MS 1

// derived cycle counts
`define ADCSQ_CONV_CYC `ADCSQ_CYC_MIN(`ADCSQ_T_CONV_NS)
`define ADCSQ_ACQ_CYC `ADCSQ_CYC_MIN(`ADCSQ_T_ACQ_NS)
`define ADCSQ_CNVMRST_CYC `ADCSQ_CYC_MIN(`ADCSQ_MUX_RESET_DELAY_AFTER_CONVERT_NS)
`define ADCSQ_MRST1_CYC `ADCSQ_CYC_MIN(`ADCSQ_MUX_RESET_DURATION_CONVERT_NS)
`define ADCSQ_VLDMRST_CYC `ADCSQ_CYC_MIN(`ADCSQ_MUX_RESET_DELAY_AFTER_WORD_NS)
`define ADCSQ_MRST2_CYC `ADCSQ_CYC_MIN(`ADCSQ_MUX_RESET_DURATION_WORD_NS)
`define ADCSQ_WAKE_CYC (`ADCSQ_T_WAKE_MS * 1000 * `ADCSQ_CLK_MHZ)

`endif

// ---- src/adcsq_sync.v ----
`timescale 1ns/10ps
module adcsq_sync #(
   parameter WIDTH = 4
) (
   input wire clk_sys,
   input wire rstn,
   input wire [WIDTH-1:0] async_in,
   output reg [WIDTH-1:0] sync_q
);
   reg [WIDTH-1:0] meta_q;

   // first stage is read only by the second stage
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         meta_q <= {WIDTH{1'b0}};
         sync_q <= {WIDTH{1'b0}};
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end
endmodule

// ---- src/adcsq_mux_timer.v ----
`timescale 1ns/10ps
module adcsq_mux_timer #(
   parameter DELAY_CYC = 4,
   parameter DUR_CYC = 12,
   parameter CW = 16
) (
   input wire clk_sys,
   input wire rstn,
   input wire start,
   output reg mux_off_q,
   output reg done_q
);
   localparam ST_IDLE = 3'b001;
   localparam ST_WAIT = 3'b010;
   localparam ST_DISCH = 3'b100;
   localparam integer DLY_LAST_I = DELAY_CYC - 1;
   localparam integer DUR_LAST_I = DUR_CYC - 1;
   localparam [CW-1:0] DLY_LAST = DLY_LAST_I[CW-1:0];
   localparam [CW-1:0] DUR_LAST = DUR_LAST_I[CW-1:0];

   reg [2:0] st_q;
   reg [CW-1:0] cnt_q;

   // a new start restarts the whole delay, so the later request sets the timing
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         st_q <= ST_IDLE;
         cnt_q <= {CW{1'b0}};
         mux_off_q <= 1'b0;
         done_q <= 1'b0;
      end else begin
         done_q <= 1'b0;
         if (start) begin
            st_q <= ST_WAIT;
            cnt_q <= DLY_LAST;
            mux_off_q <= 1'b0;
         end else begin
            case (st_q)
               ST_IDLE: begin
                  cnt_q <= {CW{1'b0}};
               end
               ST_WAIT: begin
                  if (cnt_q == {CW{1'b0}}) begin
                     st_q <= ST_DISCH;
                     cnt_q <= DUR_LAST;
                     mux_off_q <= 1'b1;
                  end else begin
                     cnt_q <= cnt_q - 1'b1;
                  end
               end
               ST_DISCH: begin
                  if (cnt_q == {CW{1'b0}}) begin
                     st_q <= ST_IDLE;
                     mux_off_q <= 1'b0;
                     done_q <= 1'b1;
                  end else begin
                     cnt_q <= cnt_q - 1'b1;
                  end
               end
               default: begin
                  st_q <= ST_IDLE;
                  mux_off_q <= 1'b0;
               end
            endcase
         end
      end
   end
endmodule

// ---- src/adcsq_ctrl.v ----
`timescale 1ns/10ps
`include "adcsq_map.vh"
module adcsq_ctrl #(
   parameter WAKE_CYC = `ADCSQ_WAKE_CYC,
   parameter CONV_CYC = `ADCSQ_CONV_CYC,
   parameter ACQ_CYC = `ADCSQ_ACQ_CYC
) (
   input wire clk_sys,
   input wire rstn,
   input wire convert_strobe,
   input wire sck,
   input wire sdi,
   input wire serial_bus_disable,
   input wire [`ADCSQ_RESULT_BITS-1:0] core_result,
   output reg busy_q,
   output reg sdo_q,
   output reg sdo_oe_q,
   output reg mux_reset_q,
   output reg [`ADCSQ_CFG_BITS-1:0] mux_cfg_q,
   output reg core_nap_q,
   output reg sleep_q,
   output reg [4:0] seq_depth_q
);

   // counts are worked out at full width, then cut to the counter width on purpose
   localparam integer FULL_DEPTH_I = `ADCSQ_SEQ_DEPTH;
   localparam integer LAST_BIT_I = `ADCSQ_CW_BITS - 1;
   localparam integer CONV_LAST_I = CONV_CYC - 1;
   localparam integer ACQ_LAST_I = ACQ_CYC - 1;
   localparam integer WAKE_LAST_I = WAKE_CYC - 1;

   // limitation: conversion and acquisition counters span at most 256 cycles,
   // the wake counter at most 262144; larger settings need wider counters
   localparam [4:0] FULL_DEPTH = FULL_DEPTH_I[4:0];
   localparam [2:0] LAST_BIT = LAST_BIT_I[2:0];
   localparam [7:0] CONV_LAST = CONV_LAST_I[7:0];
   localparam [7:0] ACQ_LAST = ACQ_LAST_I[7:0];
   localparam [17:0] WAKE_LAST = WAKE_LAST_I[17:0];


   // next slot of the sequence, wrapping after the last programmed entry
   function [3:0] next_slot;
      input [3:0] cur;
      input [4:0] depth;
      begin
         if ({1'b0, cur} + 5'h01 >= depth) begin
            next_slot = 4'h0;
         end else begin
            next_slot = cur + 4'h1;
         end
      end
   endfunction

   wire [3:0] pins_s;
   wire sck_s;
   wire sdi_s;
   wire cnv_s;
   wire dis_s;
   reg sck_prev_q;
   reg cnv_prev_q;
   wire sck_rise;
   wire sck_fall;
   wire cnv_rise;
   wire bus_en;
   wire conv_end;

   reg [`ADCSQ_CFG_BITS-1:0] seq_mem [0:`ADCSQ_SEQ_DEPTH-1];
   reg [3:0] ptr_q;
   reg [7:0] conv_cnt_q;
   reg [7:0] acq_cnt_q;
   reg acq_ok_q;
   reg [17:0] wake_cnt_q;
   reg waking_q;
   reg [`ADCSQ_CFG_BITS-1:0] conv_cfg_q;
   reg conv_first_q;
   reg [`ADCSQ_RD_BITS-1:0] out_sr_q;
   reg [`ADCSQ_RD_BITS-1:0] out_sr_d;
   reg [`ADCSQ_CW_BITS-2:0] in_sr_q;
   reg [2:0] bit_cnt_q;
   reg win_open_q;
   reg prog_seen_q;
   reg cnv_since_sck_q;
   reg sleep_req_q;
   reg conv_start;
   reg word_done;
   reg first_word;
   wire conv_mux_off;
   wire word_mux_off;
   wire conv_mux_done;
   wire word_mux_done;
   wire [`ADCSQ_CW_BITS-1:0] word_in;
   integer i;


   // the disable pin travels inverted, so the synchroniser's cleared state
   // reads as a disabled port and sdo stays off right after reset
   adcsq_sync #(
      .WIDTH(4)
   ) u_sync (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .async_in({~serial_bus_disable, convert_strobe, sdi, sck}),
      .sync_q(pins_s)
   );

   assign sck_s = pins_s[0];
   assign sdi_s = pins_s[1];
   assign cnv_s = pins_s[2];
   assign dis_s = ~pins_s[3];
   assign sck_rise = sck_s & ~sck_prev_q;
   assign sck_fall = ~sck_s & sck_prev_q;
   assign cnv_rise = cnv_s & ~cnv_prev_q;
   assign bus_en = ~dis_s;
   assign word_in = {in_sr_q, sdi_s};

   // last busy cycle: readout reload, window reopen and sleep entry share it
   assign conv_end = busy_q && (conv_cnt_q == 8'h00);


   always @* begin
      conv_start = 1'b0;
      word_done = 1'b0;
      first_word = 1'b0;
      // conversions need acquisition done, no conversion running, awake
      if (cnv_rise && !busy_q && acq_ok_q && !sleep_q && !waking_q) begin
         conv_start = 1'b1;
      end
      // programming only while not busy and the window is open
      if (bus_en && sck_rise && !busy_q && win_open_q && bit_cnt_q == LAST_BIT) begin
         word_done = 1'b1;
         first_word = ~prog_seen_q;
      end
   end

   adcsq_mux_timer #(
      .DELAY_CYC(`ADCSQ_CNVMRST_CYC),
      .DUR_CYC(`ADCSQ_MRST1_CYC),
      .CW(16)
   ) u_conv_mux (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .start(conv_start),
      .mux_off_q(conv_mux_off),
      .done_q(conv_mux_done)
   );

   adcsq_mux_timer #(
      .DELAY_CYC(`ADCSQ_VLDMRST_CYC),
      .DUR_CYC(`ADCSQ_MRST2_CYC),
      .CW(16)
   ) u_word_mux (
      .clk_sys(clk_sys),
      .rstn(rstn),
      .start(word_done & first_word),
      .mux_off_q(word_mux_off),
      .done_q(word_mux_done)
   );

   // readout shift register: loaded at busy fall, shifted on sck fall
   always @* begin
      out_sr_d = out_sr_q;
      // reload wins over a shift: a stray sck fall at busy end must not eat the msb
      if (conv_end) begin
         out_sr_d = {core_result, conv_first_q, conv_cfg_q};
      end else if (bus_en && sck_fall && !busy_q) begin
         out_sr_d = {out_sr_q[`ADCSQ_RD_BITS-2:0], 1'b0};
      end
   end

   // conversion timing, acquisition after reset, readout and pin outputs
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         sck_prev_q <= 1'b0;
         cnv_prev_q <= 1'b0;
         busy_q <= 1'b0;
         conv_cnt_q <= 8'h00;
         acq_cnt_q <= 8'h00;
         acq_ok_q <= 1'b0;
         core_nap_q <= 1'b1;
         conv_cfg_q <= `ADCSQ_RESET_CFG;
         conv_first_q <= 1'b1;
         out_sr_q <= {`ADCSQ_RD_BITS{1'b0}};
         sdo_q <= 1'b0;
         sdo_oe_q <= 1'b0;
         mux_reset_q <= 1'b0;
         mux_cfg_q <= `ADCSQ_RESET_CFG;
      end else begin
         sck_prev_q <= sck_s;
         cnv_prev_q <= cnv_s;
         out_sr_q <= out_sr_d;
         // pin is loaded from the next msb, so it changes in the same cycle as the shift register
         sdo_q <= out_sr_d[`ADCSQ_RD_BITS-1];
         sdo_oe_q <= bus_en;
         mux_reset_q <= conv_mux_off | word_mux_off;
         if (!acq_ok_q) begin
            if (acq_cnt_q == ACQ_LAST) begin
               acq_ok_q <= 1'b1;
            end else begin
               acq_cnt_q <= acq_cnt_q + 8'h01;
            end
         end
         if (conv_start) begin
            busy_q <= 1'b1;
            core_nap_q <= 1'b0;
            conv_cnt_q <= CONV_LAST;
            conv_cfg_q <= seq_mem[ptr_q];
            conv_first_q <= (ptr_q == 4'h0);
         end else if (busy_q) begin
            if (conv_cnt_q == 8'h00) begin
               busy_q <= 1'b0;
               core_nap_q <= 1'b1;
            end else begin
               conv_cnt_q <= conv_cnt_q - 8'h01;
            end
         end
         // the mux joins whatever slot the pointer names when it reconnects
         if (conv_mux_done || word_mux_done) begin
            mux_cfg_q <= seq_mem[ptr_q];
         end
      end
   end

   // sequencer memory, pointer and programming window
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         for (i = 0; i < `ADCSQ_SEQ_DEPTH; i = i + 1) begin
            seq_mem[i] <= `ADCSQ_RESET_CFG;
         end
         seq_depth_q <= `ADCSQ_RESET_DEPTH;
         ptr_q <= 4'h0;
         in_sr_q <= {(`ADCSQ_CW_BITS-1){1'b0}};
         bit_cnt_q <= 3'h0;
         win_open_q <= 1'b1;
         prog_seen_q <= 1'b0;
      end else begin
         if (conv_start) begin
            win_open_q <= 1'b0;
            ptr_q <= next_slot(ptr_q, seq_depth_q);
         end else if (conv_end) begin
            // a fresh window forgets any partial word left from the last one
            win_open_q <= 1'b1;
            bit_cnt_q <= 3'h0;
            prog_seen_q <= 1'b0;
         end else if (bus_en && sck_rise && !busy_q && win_open_q) begin
            in_sr_q <= word_in[`ADCSQ_CW_BITS-2:0];
            bit_cnt_q <= bit_cnt_q + 3'h1;
            // valid bit arrives first, so a low first bit ends the series
            if (bit_cnt_q == 3'h0 && !sdi_s) begin
               win_open_q <= 1'b0;
            end
            if (word_done) begin
               bit_cnt_q <= 3'h0;
               if (first_word) begin
                  // whole memory cleared in one cycle; costs a wide write, keeps
                  // stale entries from leaking into a shorter new sequence
                  for (i = 0; i < `ADCSQ_SEQ_DEPTH; i = i + 1) begin
                     seq_mem[i] <= `ADCSQ_RESET_CFG;
                  end
                  seq_mem[0] <= word_in[`ADCSQ_CFG_BITS-1:0];
                  seq_depth_q <= 5'h01;
                  ptr_q <= 4'h0;
                  prog_seen_q <= 1'b1;
               end else begin
                  seq_mem[seq_depth_q[3:0]] <= word_in[`ADCSQ_CFG_BITS-1:0];
                  seq_depth_q <= seq_depth_q + 5'h01;
                  if (seq_depth_q + 5'h01 == FULL_DEPTH) begin
                     win_open_q <= 1'b0;
                  end
               end
            end
         end
      end
   end

   // sleep request, entry and wake; sck edges count here even with the bus off
   always @(posedge clk_sys or negedge rstn) begin
      if (!rstn) begin
         cnv_since_sck_q <= 1'b0;
         sleep_req_q <= 1'b0;
         sleep_q <= 1'b0;
         waking_q <= 1'b0;
         wake_cnt_q <= 18'h00000;
      end else begin
         if (sck_rise) begin
            cnv_since_sck_q <= 1'b0;
            sleep_req_q <= 1'b0;
         end else if (conv_start) begin
            cnv_since_sck_q <= 1'b1;
            if (cnv_since_sck_q) begin
               sleep_req_q <= 1'b1;
            end
         end

         // conv_start cannot fall in a busy cycle, so only the stored request counts
         if (conv_end && sleep_req_q) begin
            sleep_q <= 1'b1;
            sleep_req_q <= 1'b0;
         end else if (sleep_q && sck_rise) begin
            sleep_q <= 1'b0;
            waking_q <= 1'b1;
            wake_cnt_q <= WAKE_LAST;
         end else if (waking_q) begin
            // conversions held off until references have settled
            if (wake_cnt_q == 18'h00000) begin
               waking_q <= 1'b0;
            end else begin
               wake_cnt_q <= wake_cnt_q - 18'h00001;
            end
         end
      end
   end
endmodule

// ---- bench/adcsq_ctrl_monitor.sv ----
`timescale 1ns/10ps
module adcsq_ctrl_monitor (
   input wire clk_sys,
   input wire rstn,
   input wire convert_strobe,
   input wire sck,
   input wire sdi,
   input wire serial_bus_disable,
   input wire [15:0] core_result,
   input wire busy_q,
   input wire sdo_q,
   input wire sdo_oe_q,
   input wire mux_reset_q,
   input wire [6:0] mux_cfg_q,
   input wire core_nap_q,
   input wire sleep_q,
   input wire [4:0] seq_depth_q
);
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rstn);
   property p_nap;
      busy_q |-> !core_nap_q;
   endproperty
   a_nap: assert property (p_nap) else $error("core napping while busy");
   // pin runs through a synchroniser, so the level must settle first
   property p_off;
      serial_bus_disable [*8] |-> !sdo_oe_q;
   endproperty
   a_off: assert property (p_off) else $error("sdo driven while disabled");
   property p_on;
      !serial_bus_disable [*8] |-> sdo_oe_q;
   endproperty
   a_on: assert property (p_on) else $error("sdo not driven while enabled");
   property p_mux_go;
      $rose(busy_q) |-> ##[1:12] mux_reset_q;
   endproperty
   a_mux_go: assert property (p_mux_go) else $error("no mux reset after start");
   property p_cfg_late;
      $changed(mux_cfg_q) |-> $past(mux_reset_q);
   endproperty
   a_cfg_late: assert property (p_cfg_late) else $error("cfg moved off reconnect");
   property p_msb;
      $fell(busy_q) && !serial_bus_disable |-> ##[0:2] sdo_q == core_result[15];
   endproperty
   a_msb: assert property (p_msb) else $error("msb missing after busy fall");
   property p_depth;
      seq_depth_q != 5'h00 && seq_depth_q <= 5'h10;
   endproperty
   a_depth: assert property (p_depth) else $error("depth out of range");
   property p_depth_idle;
      $changed(seq_depth_q) |-> !busy_q && !$past(busy_q);
   endproperty
   a_depth_idle: assert property (p_depth_idle) else $error("depth moved while busy");
   property p_sleep;
      $rose(sleep_q) |-> !busy_q && ($past(busy_q) || $past(busy_q, 2));
   endproperty
   a_sleep: assert property (p_sleep) else $error("sleep not at busy fall");
   c_conv: cover property ($rose(busy_q));
   c_prog: cover property ($changed(seq_depth_q));
   c_sleep: cover property ($rose(sleep_q));
endmodule
bind adcsq_ctrl adcsq_ctrl_monitor u_mon (
   .clk_sys, .rstn, .convert_strobe, .sck, .sdi, .serial_bus_disable, .core_result,
   .busy_q, .sdo_q, .sdo_oe_q, .mux_reset_q, .mux_cfg_q, .core_nap_q, .sleep_q,
   .seq_depth_q
);

// ---- bench/adcsq_host.sv ----
`timescale 1ns/10ps
module adcsq_host (
   input wire clk_sys,
   input wire busy_q,
   input wire sdo_q,
   output reg convert_strobe,
   output reg sck,
   output reg sdi,
   output reg serial_bus_disable
);
   // a shared bus idles with this device deselected
   initial begin
      convert_strobe = 1'b0;
      sck = 1'b0;
      sdi = 1'b0;
      serial_bus_disable = 1'b1;
   end
   task bus(input v);
      @(posedge clk_sys) #1 serial_bus_disable = v;
   endtask
   task pulse;
      begin
         @(posedge clk_sys) #1 convert_strobe = 1'b1;
         repeat (4) @(posedge clk_sys);
         #1 convert_strobe = 1'b0;
      end
   endtask
   // ok stays low when the request was dropped
   task conv(output ok);
      integer n;
      begin
         pulse;
         n = 0;
         while (busy_q !== 1'b1 && n < 20) begin
            @(posedge clk_sys);
            n = n + 1;
         end
         ok = (busy_q === 1'b1);
         while (busy_q !== 1'b0 && n < 400) begin
            @(posedge clk_sys);
            n = n + 1;
         end
         repeat (2) @(posedge clk_sys);
      end
   endtask
   // sck rests low between frames; sdo is taken just before each rise
   task frame(input [23:0] din, output [23:0] dout);
      integer i;
      begin
         #1;
         for (i = 23; i >= 0; i = i - 1) begin
            sdi = din[i];
            #32 dout[i] = sdo_q;
            sck = 1'b1;
            #32 sck = 1'b0;
         end
      end
   endtask
   task wake;
      begin
         sck = 1'b1;
         #32 sck = 1'b0;
         #32;
      end
   endtask
endmodule

// ---- bench/tb.sv ----
`timescale 1ns/10ps
module tb;
   reg clk_sys = 1'b0;
   reg rstn = 1'b0;
   reg [15:0] core_result = 16'h0000;
   reg [23:0] rd;
   reg ok;
   integer k;
   integer failures = 0;
   integer tests_run = 0;
   wire convert_strobe, sck, sdi, serial_bus_disable;
   wire busy_q, sdo_q, sdo_oe_q, mux_reset_q, core_nap_q, sleep_q;
   wire [6:0] mux_cfg_q;
   wire [4:0] seq_depth_q;
   initial forever #2.5 clk_sys = ~clk_sys;
   // short wake time keeps the sleep scenario brief
   adcsq_ctrl #(.WAKE_CYC(50)) u_dut (
      .clk_sys, .rstn, .convert_strobe, .sck, .sdi, .serial_bus_disable, .core_result,
      .busy_q, .sdo_q, .sdo_oe_q, .mux_reset_q, .mux_cfg_q, .core_nap_q, .sleep_q,
      .seq_depth_q
   );
   adcsq_host u_host (
      .clk_sys, .busy_q, .sdo_q, .convert_strobe, .sck, .sdi, .serial_bus_disable
   );
   task check(input [31:0] seen, input [31:0] exp);
      begin
         tests_run = tests_run + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task report_and_stop;
      begin
         if (failures == 0 && tests_run > 0)
            $display("Testbench passed");
         else
            $display("Testbench failed");
         $finish;
      end
   endtask
   // step off the edge so outputs launched on it have settled
   task cyc(input integer n);
      begin
         repeat (n) @(posedge clk_sys);
         #1;
      end
   endtask
   task convrd(input [15:0] r, input [23:0] din, input [23:0] exp);
      begin
         @(posedge clk_sys) #1 core_result = r;
         u_host.conv(ok);
         check(ok, 1'b1);
         u_host.frame(din, rd);
         check(rd, exp);
      end
   endtask
   initial begin
      cyc(8);
      #1 rstn = 1'b1;
      cyc(2);
      check(seq_depth_q, 5'h01);
      check(mux_cfg_q, 7'h00);
      check(sdo_oe_q, 1'b0);
      u_host.bus(1'b0);
      cyc(80);
      convrd(16'ha5c3, 24'h000000, {16'ha5c3, 8'h80});
      convrd(16'h3c5a, 24'hb78b00, {16'h3c5a, 8'h80});
      check(seq_depth_q, 5'h02);
      check(mux_cfg_q, 7'h37);
      for (k = 0; k < 3; k = k + 1) begin
         convrd(16'h1000 + k[15:0], 24'h0, {16'h1000 + k[15:0], k[0] ? 8'h0b : 8'hb7});
         check(mux_cfg_q, k[0] ? 7'h37 : 7'h0b);
      end
      u_host.bus(1'b1);
      cyc(10);
      check(sdo_oe_q, 1'b0);
      @(posedge clk_sys) #1 core_result = 16'h8421;
      u_host.conv(ok);
      u_host.frame(24'h818283, rd);
      check(seq_depth_q, 5'h02);
      u_host.bus(1'b0);
      cyc(10);
      check(sdo_oe_q, 1'b1);
      check(sdo_q, 1'b1);
      u_host.frame(24'h000000, rd);
      check(rd, {16'h8421, 8'h0b});
      cyc(100);
      u_host.conv(ok);
      cyc(100);
      u_host.conv(ok);
      check(sleep_q, 1'b1);
      u_host.conv(ok);
      check(ok, 1'b0);
      u_host.wake;
      cyc(6);
      check(sleep_q, 1'b0);
      u_host.conv(ok);
      check(ok, 1'b0);
      cyc(60);
      convrd(16'h7e7e, 24'h000000, {16'h7e7e, 8'hb7});
      u_host.pulse;
      cyc(10);
      check(busy_q, 1'b1);
      #1 rstn = 1'b0;
      cyc(2);
      check(busy_q, 1'b0);
      check(sdo_oe_q, 1'b0);
      check(seq_depth_q, 5'h01);
      #1 rstn = 1'b1;
      u_host.conv(ok);
      check(ok, 1'b0);
      cyc(80);
      convrd(16'h5a5a, 24'h000000, {16'h5a5a, 8'h80});
      report_and_stop;
   end
   initial begin
      #200000;
      failures = failures + 1;
      report_and_stop;
   end
endmodule
